//--- shared/irb_pkg.sv
// package: offsets, field positions, reset values and carrier types of the request bank
package irb_pkg;

  // ----------------------------------------------------------------------
  // register byte addresses (offsets are word indices, byte = 4 x index)
  // ----------------------------------------------------------------------
  localparam logic [11:0] IDX_G1_ENABLE_LOW  = 12'hFC5;
  localparam logic [11:0] IDX_G2_FLAGS       = 12'hFC6;
  localparam logic [11:0] IDX_G2_ENABLE_HIGH = 12'hFC7;
  localparam logic [11:0] IDX_G2_ENABLE_LOW  = 12'hFC8;
  localparam logic [11:0] IDX_G1_ENABLE_HIGH = 12'hFC4;
  localparam logic [11:0] IDX_PORT_SELECT    = 12'hFCE;
  localparam logic [11:0] IDX_CONTROL        = 12'hFCF;
  localparam logic [11:0] IDX_G1_PENDING     = 12'hFD0;
  localparam logic [11:0] IDX_IRQ_STATUS     = 12'hFD1;
  localparam logic [11:0] IDX_IRQ_MASK       = 12'hFD2;
  localparam logic [11:0] IDX_VECTOR         = 12'hFD3;

  localparam logic [13:0] ADDR_G1_ENABLE_LOW  = {IDX_G1_ENABLE_LOW, 2'h0};
  localparam logic [13:0] ADDR_G2_FLAGS       = {IDX_G2_FLAGS, 2'h0};
  localparam logic [13:0] ADDR_G2_ENABLE_HIGH = {IDX_G2_ENABLE_HIGH, 2'h0};
  localparam logic [13:0] ADDR_G2_ENABLE_LOW  = {IDX_G2_ENABLE_LOW, 2'h0};
  localparam logic [13:0] ADDR_G1_ENABLE_HIGH = {IDX_G1_ENABLE_HIGH, 2'h0};
  localparam logic [13:0] ADDR_PORT_SELECT    = {IDX_PORT_SELECT, 2'h0};
  localparam logic [13:0] ADDR_CONTROL        = {IDX_CONTROL, 2'h0};
  localparam logic [13:0] ADDR_G1_PENDING     = {IDX_G1_PENDING, 2'h0};
  localparam logic [13:0] ADDR_IRQ_STATUS     = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [13:0] ADDR_IRQ_MASK       = {IDX_IRQ_MASK, 2'h0};
  localparam logic [13:0] ADDR_VECTOR         = {IDX_VECTOR, 2'h0};

  // ----------------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------------
  localparam int          G2_RESERVED_BIT   = 7;
  localparam int          G2_TIMER_BIT      = 6;
  localparam int          G2_UART_RX_BIT    = 5;
  localparam int          G2_UART_TX_BIT    = 4;
  localparam int          GLOBAL_ENABLE_BIT = 7;
  localparam int          SEL_PIN5_BIT      = 5;
  localparam logic [7:0]  G2_WRITABLE       = 8'h7F;
  localparam logic [7:0]  SEL_WRITABLE      = 8'h3E;
  localparam logic [7:0]  REG_RESET         = 8'h00;
  localparam logic [1:0]  PRIO_OFF          = 2'h0;
  localparam logic [4:0]  NO_VECTOR         = 5'h1F;
  localparam logic [4:0]  G2_VECTOR_BASE    = 5'h08;
  localparam int          EVT_TAKEN_BIT     = 0;
  localparam int          EVT_ACK_BIT       = 1;
  localparam logic [31:0] BUS_ZERO          = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] port_a_pin;
    logic [4:1] port_d_pin;
    logic       voltage_detect;
    logic       comparator0;
    logic       comparator1;
  } irb_g1_src_t;

  typedef struct packed {
    logic       multichannel_timer_request;
    logic       uart_b_receive_request;
    logic       uart_b_transmit_request;
    logic [3:0] port_c_pin_request;
  } irb_g2_src_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] vector;
    logic [1:0] level;
  } irb_core_req_t;

endpackage : irb_pkg

//--- sim/irb_bank_asserts.sv
// checker: port-level properties of the request bank
`timescale 1ns/1ns
`default_nettype none
module irb_bank_asserts (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [13:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  input wire irb_pkg::irb_g1_src_t   g1_src_raw,
  input wire irb_pkg::irb_g2_src_t   g2_src_raw,
  input wire logic                   cpu_enable_int,
  input wire logic                   cpu_disable_int,
  input wire logic                   cpu_int_return,
  input wire logic                   cpu_ack,
  input wire irb_pkg::irb_core_req_t core_req,
  input wire logic                   irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_IDLE_ZERO: assert property (!pready |-> prdata == irb_pkg::BUS_ZERO && !pslverr)
    else $error("read data or error outside answer");
  AST_FLAGS_TOP: assert property (pready && !pwrite && paddr == irb_pkg::ADDR_G2_FLAGS
    |-> prdata[31:7] == 25'h0)
    else $error("top flag bit reads nonzero");
  AST_VALID_LEVEL: assert property (core_req.valid
    |-> core_req.level != irb_pkg::PRIO_OFF && core_req.vector != irb_pkg::NO_VECTOR)
    else $error("request forwarded without a level");
  AST_ACK_DROPS: assert property (cpu_ack && core_req.valid && !cpu_enable_int
    && !cpu_int_return |-> ##[1:2] !core_req.valid)
    else $error("request stays after acknowledge");
  AST_DISABLE_HOLDS: assert property (cpu_disable_int && !cpu_enable_int
    && !cpu_int_return && !psel ##1 !cpu_enable_int && !cpu_int_return && !psel
    |=> !core_req.valid)
    else $error("core interrupted while disabled");
  AST_VALID_HOLDS: assert property (core_req.valid && !cpu_ack && !cpu_disable_int
    && !psel && !$past(psel) && !$past(cpu_disable_int) |=> core_req.valid)
    else $error("pending request vanished");
  AST_SLVERR_READY: assert property (pslverr |-> pready && prdata == irb_pkg::BUS_ZERO)
    else $error("error without answer");
  cover property (cpu_ack && core_req.valid);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule : irb_bank_asserts
bind irb_bank irb_bank_asserts i_irb_bank_asserts (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .g1_src_raw(g1_src_raw),
  .g2_src_raw(g2_src_raw), .cpu_enable_int(cpu_enable_int), .cpu_disable_int(cpu_disable_int),
  .cpu_int_return(cpu_int_return), .cpu_ack(cpu_ack), .core_req(core_req), .irq(irq));
`default_nettype wire

//--- sim/irb_core_model.sv
// model: processor core taking vectored requests
`timescale 1ns/1ns
`default_nettype none
module irb_core_model (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire irb_pkg::irb_core_req_t core_req,
  input  wire logic [3:0]             ack_wait,
  output logic                        cpu_ack,
  output logic [6:0]                  taken,
  output logic [7:0]                  acks
);
  logic [3:0] waited;
  logic [1:0] cool;
  // ----------------------------------------------------------------
  // acknowledge
  // ----------------------------------------------------------------
  // ack only while valid
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpu_ack <= 1'b0;
      waited  <= 4'h0;
      cool    <= 2'h0;
      taken   <= 7'h00;
      acks    <= 8'h00;
    end else if (cpu_ack || cool != 2'h0) begin
      cpu_ack <= 1'b0;
      waited  <= 4'h0;
      cool    <= cpu_ack ? 2'h3 : cool - 2'h1;
    end else if (core_req.valid && waited >= ack_wait) begin
      cpu_ack <= 1'b1;
      taken   <= {core_req.level, core_req.vector};
      acks    <= acks + 8'h01;
    end else begin
      waited  <= core_req.valid ? waited + 4'h1 : 4'h0;
    end
  end
endmodule : irb_core_model
`default_nettype wire

//--- sim/testbench.sv
// bench: register, request and core-handshake tests of the request bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic                   mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic                   cpu_enable_int, cpu_disable_int, cpu_int_return, cpu_ack;
  logic [13:0]            paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic [3:0]             pstrb, ack_wait;
  logic [6:0]             taken;
  logic [7:0]             acks;
  irb_pkg::irb_g1_src_t   g1;
  irb_pkg::irb_g2_src_t   g2;
  irb_pkg::irb_core_req_t core_req;
  int                     fails, comparisons;
  irb_bank i_irb_bank (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .g1_src_raw(g1), .g2_src_raw(g2),
    .cpu_enable_int(cpu_enable_int), .cpu_disable_int(cpu_disable_int),
    .cpu_int_return(cpu_int_return), .cpu_ack(cpu_ack), .core_req(core_req), .irq(irq));
  irb_core_model i_irb_core_model (.mclk(mclk), .rst_n(rst_n), .core_req(core_req),
    .ack_wait(ack_wait), .cpu_ack(cpu_ack), .taken(taken), .acks(acks));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rchk(input logic [13:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00, rd, err);
    `CHK(rd, {24'h000000, x})
  endtask : rchk
  task automatic pulse(input int k);
    @(posedge mclk);
    cpu_enable_int <= (k == 0);
    cpu_disable_int <= (k == 1);
    cpu_int_return <= (k == 2);
    @(posedge mclk);
    {cpu_enable_int, cpu_disable_int, cpu_int_return} <= 3'h0;
  endtask : pulse
  task automatic wait_ack(input logic [7:0] n0);
    int t;
    t = 0;
    while (acks === n0 && t < 60) begin
      @(posedge mclk);
      t++;
    end
    `CHK(acks, n0 + 8'h01)
  endtask : wait_ack
  task automatic print_verdict;
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    print_verdict;
  end
  initial begin
    {rst_n, psel, penable, pwrite, cpu_enable_int, cpu_disable_int, cpu_int_return} = 7'h00;
    paddr = 14'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    ack_wait = 4'h0;
    g1 = '0;
    g2 = '0;
    fails = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(irb_pkg::ADDR_G1_ENABLE_LOW, 8'h00);
    rchk(irb_pkg::ADDR_G2_FLAGS, 8'h00);
    apb(1'b0, 14'h0004, 8'h00, rd, err);
    `CHK(err, 1'b1)
    wr(irb_pkg::ADDR_G1_ENABLE_LOW, 8'hA5);
    rchk(irb_pkg::ADDR_G1_ENABLE_LOW, 8'hA5);
    wr(irb_pkg::ADDR_G1_ENABLE_LOW, 8'h5A);
    rchk(irb_pkg::ADDR_G1_ENABLE_LOW, 8'h5A);
    wr(irb_pkg::ADDR_G2_FLAGS, 8'h7F);
    rchk(irb_pkg::ADDR_G2_FLAGS, 8'h7F);
    wr(irb_pkg::ADDR_G2_FLAGS, 8'h00);
    wr(irb_pkg::ADDR_G2_ENABLE_LOW, 8'h50);
    wr(irb_pkg::ADDR_G2_ENABLE_HIGH, 8'h10);
    for (int i = 0; i < 7; i++) begin
      g2 <= irb_pkg::irb_g2_src_t'(7'h01 << i);
      repeat (6) @(posedge mclk);
      g2 <= '0;
      rchk(irb_pkg::ADDR_G2_FLAGS, 8'h01 << i);
      `CHK(core_req.valid, 1'b0)
      wr(irb_pkg::ADDR_G2_FLAGS, 8'h00);
    end
    wr(irb_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(irb_pkg::ADDR_CONTROL, 8'h80);
    ack_wait <= 4'h3;
    g2 <= irb_pkg::irb_g2_src_t'(7'h50);
    wait_ack(8'h00);
    `CHK(taken, {2'h3, 5'h0C})
    g2 <= '0;
    rchk(irb_pkg::ADDR_CONTROL, 8'h00);
    rchk(irb_pkg::ADDR_G2_FLAGS, 8'h40);
    `CHK(irq, 1'b1)
    rchk(irb_pkg::ADDR_IRQ_STATUS, 8'h03);
    wr(irb_pkg::ADDR_IRQ_STATUS, 8'h03);
    rchk(irb_pkg::ADDR_IRQ_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    ack_wait <= 4'h0;
    pulse(2);
    wait_ack(8'h01);
    `CHK(taken, {2'h1, 5'h0E})
    rchk(irb_pkg::ADDR_G2_FLAGS, 8'h00);
    pulse(0);
    rchk(irb_pkg::ADDR_CONTROL, 8'h80);
    pulse(1);
    rchk(irb_pkg::ADDR_CONTROL, 8'h00);
    wr(irb_pkg::ADDR_PORT_SELECT, 8'h02);
    wr(irb_pkg::ADDR_G1_ENABLE_LOW, 8'h02);
    wr(irb_pkg::ADDR_CONTROL, 8'h80);
    g1.port_d_pin <= 4'h1;
    wait_ack(8'h02);
    `CHK(taken, {2'h1, 5'h01})
    rchk(irb_pkg::ADDR_VECTOR, 8'h1F);
    wr(irb_pkg::ADDR_PORT_SELECT, 8'h22);
    g1.comparator1 <= 1'b1;
    g1.voltage_detect <= 1'b1;
    repeat (6) @(posedge mclk);
    rchk(irb_pkg::ADDR_G1_PENDING, 8'hA0);
    wr(irb_pkg::ADDR_G1_PENDING, 8'hA0);
    rchk(irb_pkg::ADDR_G1_PENDING, 8'h00);
    pstrb <= 4'h0;
    wr(irb_pkg::ADDR_G1_ENABLE_HIGH, 8'h80);
    pstrb <= 4'hF;
    rchk(irb_pkg::ADDR_G1_ENABLE_HIGH, 8'h00);
    wr(irb_pkg::ADDR_G1_ENABLE_HIGH, 8'h80);
    rchk(irb_pkg::ADDR_G1_ENABLE_HIGH, 8'h80);
    print_verdict;
  end
endmodule : testbench
`default_nettype wire

//--- src/irb_arbiter.sv
// module: picks the highest-priority enabled pending request
`timescale 1ns/1ns
`default_nettype none

module irb_arbiter (
  input  wire logic [15:0] pending,
  input  wire logic [15:0] enable_high,
  input  wire logic [15:0] enable_low,
  output logic             found,
  output logic [4:0]       vector,
  output logic [1:0]       level
);

  logic [1:0] code [16];

  // ----------------------------------------------------------------------
  // per-source priority code
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_code
      assign code[g] = pending[g] ? {enable_high[g], enable_low[g]} : irb_pkg::PRIO_OFF;
    end
  endgenerate

  // lowest index wins among equals: higher level scanned first
  always_comb begin
    found  = 1'b0;
    vector = irb_pkg::NO_VECTOR;
    level  = irb_pkg::PRIO_OFF;
    for (int lv = 3; lv >= 1; lv--) begin
      for (int i = 15; i >= 0; i--) begin
        if (!found && code[i] == 2'(lv)) begin
          vector = 5'(i);
        end
      end
      if (!found && vector != irb_pkg::NO_VECTOR) begin
        found = 1'b1;
        level = 2'(lv);
      end
    end
  end

endmodule : irb_arbiter

`default_nettype wire

//--- src/irb_bank.sv
// module: interrupt request flags and priority enables behind an APB slave
//
// Function
// - a group-two source request sets its flag bit to one
// - global enable on: pending enabled group-two request goes to core vectored
// - global enable off: no core interrupt; flags stay readable for polling
// - group-two bit 6 is the multi-channel timer request flag
// - group-two bit 5 is the second UART receive request flag
// - group-two bit 4 is the second UART transmit request flag
// - group-two bits 3..0 are port C pin 3..0 request flags
// - group-one low enable bit 7: port A pin 7 or voltage detector
// - group-one low enable bit 6: port A pin 6 or comparator 0
// - group-one low enable bit 5: port A pin 5 or comparator 1
// - group-one low enable bits 4..1: shared port A / port D pins
// - high and low enable bits form priority code, 00 disabled
// - global enable set by enable/return/write one, cleared by disable/ack/reset/zero
// - select bits 4..1 pick port A pin (0) or port D pin (1); select bit 5 picks port A pin 5 (0) or comparator 1 (1)
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module irb_bank (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [13:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire irb_pkg::irb_g1_src_t   g1_src_raw,
  input  wire irb_pkg::irb_g2_src_t   g2_src_raw,
  input  wire logic                   cpu_enable_int,
  input  wire logic                   cpu_disable_int,
  input  wire logic                   cpu_int_return,
  input  wire logic                   cpu_ack,
  output irb_pkg::irb_core_req_t      core_req,
  output logic                        irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  irb_pkg::irb_g1_src_t g1_meta;
  irb_pkg::irb_g1_src_t g1_sync;
  irb_pkg::irb_g1_src_t g1_prev;
  irb_pkg::irb_g2_src_t g2_meta;
  irb_pkg::irb_g2_src_t g2_sync;
  irb_pkg::irb_g2_src_t g2_prev;
  logic [7:0]  g1_flags;
  logic [7:0]  g2_flags;
  logic [7:0]  g1_en_high;
  logic [7:0]  g1_en_low;
  logic [7:0]  g2_en_high;
  logic [7:0]  g2_en_low;
  logic [7:0]  port_select;
  logic        global_enable;
  logic [1:0]  evt_status;
  logic [1:0]  evt_mask;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire        bus_access = psel && penable;
  wire        bus_wr     = bus_access && pwrite && pstrb[0];
  wire [7:0]  wbyte      = pwdata[7:0];
  wire        hit_g1el   = paddr == irb_pkg::ADDR_G1_ENABLE_LOW;
  wire        hit_g1eh   = paddr == irb_pkg::ADDR_G1_ENABLE_HIGH;
  wire        hit_g2f    = paddr == irb_pkg::ADDR_G2_FLAGS;
  wire        hit_g2eh   = paddr == irb_pkg::ADDR_G2_ENABLE_HIGH;
  wire        hit_g2el   = paddr == irb_pkg::ADDR_G2_ENABLE_LOW;
  wire        hit_sel    = paddr == irb_pkg::ADDR_PORT_SELECT;
  wire        hit_ctl    = paddr == irb_pkg::ADDR_CONTROL;
  wire        hit_g1p    = paddr == irb_pkg::ADDR_G1_PENDING;
  wire        hit_st     = paddr == irb_pkg::ADDR_IRQ_STATUS;
  wire        hit_mask   = paddr == irb_pkg::ADDR_IRQ_MASK;
  wire        hit_vec    = paddr == irb_pkg::ADDR_VECTOR;
  wire        hit_any    = hit_g1el | hit_g1eh | hit_g2f | hit_g2eh | hit_g2el | hit_sel
                         | hit_ctl | hit_g1p | hit_st | hit_mask | hit_vec;

  // ----------------------------------------------------------------------
  // source selection and edge detect
  // ----------------------------------------------------------------------
  wire [7:0] g1_line;
  assign g1_line[0]   = g1_sync.port_a_pin[0];
  assign g1_line[4:1] = (g1_sync.port_a_pin[4:1] & ~port_select[4:1])
                      | (g1_sync.port_d_pin & port_select[4:1]);
  assign g1_line[5]   = port_select[irb_pkg::SEL_PIN5_BIT] ? g1_sync.comparator1
                                                           : g1_sync.port_a_pin[5];
  assign g1_line[6]   = g1_sync.port_a_pin[6] | g1_sync.comparator0;
  assign g1_line[7]   = g1_sync.port_a_pin[7] | g1_sync.voltage_detect;

  wire [7:0] g1_prev_line;
  assign g1_prev_line[0]   = g1_prev.port_a_pin[0];
  assign g1_prev_line[4:1] = (g1_prev.port_a_pin[4:1] & ~port_select[4:1])
                           | (g1_prev.port_d_pin & port_select[4:1]);
  assign g1_prev_line[5]   = port_select[irb_pkg::SEL_PIN5_BIT] ? g1_prev.comparator1
                                                                : g1_prev.port_a_pin[5];
  assign g1_prev_line[6]   = g1_prev.port_a_pin[6] | g1_prev.comparator0;
  assign g1_prev_line[7]   = g1_prev.port_a_pin[7] | g1_prev.voltage_detect;

  wire [7:0] g1_rise = g1_line & ~g1_prev_line;
  // request sets flag; bit placement, bit 7 none
  wire [7:0] g2_rise = {1'b0, g2_sync & ~g2_prev};

  // ----------------------------------------------------------------------
  // arbitration toward the core
  // ----------------------------------------------------------------------
  logic       arb_found;
  logic [4:0] arb_vector;
  logic [1:0] arb_level;

  irb_arbiter u_arbiter (
    .pending     ({g2_flags, g1_flags}),
    .enable_high ({g2_en_high, g1_en_high}),
    .enable_low  ({g2_en_low, g1_en_low}),
    .found       (arb_found),
    .vector      (arb_vector),
    .level       (arb_level)
  );

  // vectored only when enabled; silent otherwise
  wire       next_valid  = global_enable && arb_found && !cpu_ack;
  wire [4:0] ack_vector  = core_req.vector;
  wire [15:0] ack_onehot = (core_req.valid && cpu_ack) ? (16'h0001 << ack_vector[3:0])
                                                       : 16'h0000;

  // hold until ack or write clear; set wins
  wire [7:0] g1_wclr     = (bus_wr && hit_g1p) ? wbyte : 8'h00;
  wire [7:0] g2_wclr     = (bus_wr && hit_g2f) ? (~wbyte & irb_pkg::G2_WRITABLE) : 8'h00;
  wire [7:0] g2_wset     = (bus_wr && hit_g2f) ? (wbyte & irb_pkg::G2_WRITABLE) : 8'h00;
  wire [7:0] next_g1     = (g1_flags & ~g1_wclr & ~ack_onehot[7:0]) | g1_rise;
  wire [7:0] next_g2     = ((g2_flags & ~g2_wclr & ~ack_onehot[15:8]) | g2_rise | g2_wset)
                         & irb_pkg::G2_WRITABLE;

  wire ge_wr    = bus_wr && hit_ctl;
  wire next_ge  = (cpu_enable_int || cpu_int_return) ? 1'b1
                : (cpu_disable_int || (core_req.valid && cpu_ack)) ? 1'b0
                : ge_wr ? wbyte[irb_pkg::GLOBAL_ENABLE_BIT]
                : global_enable;

  // ----------------------------------------------------------------------
  // sticky event status (bit 0: vector offered, bit 1: acknowledged)
  // ----------------------------------------------------------------------
  wire [1:0] evt_set    = {core_req.valid && cpu_ack, next_valid && !core_req.valid};
  wire [1:0] evt_clr    = (bus_wr && hit_st) ? wbyte[1:0] : 2'h0;
  wire [1:0] next_evt   = (evt_status & ~evt_clr) | evt_set;
  wire       next_irq   = |(next_evt & evt_mask);

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  wire [7:0] rd_byte =
      hit_g1el ? g1_en_low :
      hit_g1eh ? g1_en_high :
      hit_g2f  ? g2_flags :
      hit_g2eh ? g2_en_high :
      hit_g2el ? g2_en_low :
      hit_sel  ? port_select :
      hit_ctl  ? {global_enable, 7'h00} :
      hit_g1p  ? g1_flags :
      hit_st   ? {6'h00, evt_status} :
      hit_mask ? {6'h00, evt_mask} :
      hit_vec  ? {1'b0, core_req.level, core_req.vector} :
                 8'h00;

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      g1_meta <= '0;
      g1_sync <= '0;
      g1_prev <= '0;
      g2_meta <= '0;
      g2_sync <= '0;
      g2_prev <= '0;
    end else begin
      g1_meta <= g1_src_raw;
      g1_sync <= g1_meta;
      g1_prev <= g1_sync;
      g2_meta <= g2_src_raw;
      g2_sync <= g2_meta;
      g2_prev <= g2_sync;
    end
  end

  // ----------------------------------------------------------------------
  // flags, enables and control
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      g1_flags      <= irb_pkg::REG_RESET;
      g2_flags      <= irb_pkg::REG_RESET;
      g1_en_high    <= irb_pkg::REG_RESET;
      g1_en_low     <= irb_pkg::REG_RESET;
      g2_en_high    <= irb_pkg::REG_RESET;
      g2_en_low     <= irb_pkg::REG_RESET;
      port_select   <= irb_pkg::REG_RESET;
      global_enable <= 1'b0;
    end else begin
      g1_flags      <= next_g1;
      g2_flags      <= next_g2;
      global_enable <= next_ge;
      if (bus_wr && hit_g1el) begin
        g1_en_low <= wbyte;
      end
      if (bus_wr && hit_g1eh) begin
        g1_en_high <= wbyte;
      end
      if (bus_wr && hit_g2eh) begin
        g2_en_high <= wbyte;
      end
      if (bus_wr && hit_g2el) begin
        g2_en_low <= wbyte;
      end
      if (bus_wr && hit_sel) begin
        port_select <= wbyte & irb_pkg::SEL_WRITABLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // core request, interrupt line and bus answer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      core_req   <= '0;
      evt_status <= 2'h0;
      evt_mask   <= 2'h0;
      irq        <= 1'b0;
      pready     <= 1'b0;
      prdata     <= irb_pkg::BUS_ZERO;
      pslverr    <= 1'b0;
    end else begin
      core_req.valid  <= next_valid;
      core_req.vector <= next_valid ? arb_vector : irb_pkg::NO_VECTOR;
      core_req.level  <= next_valid ? arb_level : irb_pkg::PRIO_OFF;
      evt_status      <= next_evt;
      irq             <= next_irq;
      if (bus_wr && hit_mask) begin
        evt_mask <= wbyte[1:0];
      end
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : irb_pkg::BUS_ZERO;
    end
  end

endmodule : irb_bank

`default_nettype wire
